// File: bench/capcmp_monitor.sv
// Purpose: Port-level properties of the capture/compare block
// Assumes: One clock domain, synchronous active-low reset
// Notes: Bound to every instance of the block
`timescale 1ns/1ps
`default_nettype none
module capcmp_monitor
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Counter and control
   input wire logic [15:0] counter_value,
   input wire logic timer_tick,
   input wire logic count_top,
   input wire logic count_bottom,
   input wire logic [3:0] waveform_mode_bits,
   input wire logic compare_irq_enable_a,
   // CPU side
   input wire logic capture_low_write,
   input wire logic capture_low_read,
   input wire logic compare_flag_a_clear,
   input wire logic [7:0] cpu_rdata,
   // Observed outputs
   input wire logic capture_flag,
   input wire logic compare_flag_a,
   input wire logic compare_irq_a,
   input wire logic match_a,
   input wire logic [15:0] capture_value_reg,
   input wire logic [15:0] compare_value_a
);
   wire logic cap_top = waveform_mode_bits[3] && !waveform_mode_bits[0];
   wire logic pwm = !(waveform_mode_bits inside {4'h0, 4'h4, 4'hC, 4'hD});
   wire logic reload = timer_tick && (count_top || count_bottom);
   wire logic equal_a = counter_value == compare_value_a;
   wire logic [7:0] cap_low = capture_value_reg[7:0];
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   property p_cap_load;
      $changed(capture_value_reg) && !$past(capture_low_write) |-> capture_flag;
   endproperty
   a_cap_load: assert property (p_cap_load) else $error("no flag on load");
   // Two cycles of TOP mode, so a mode change never races the detector
   property p_cap_idle;
      $past(cap_top) && $past(cap_top, 2) && !$past(capture_low_write)
         |-> $stable(capture_value_reg);
   endproperty
   a_cap_idle: assert property (p_cap_idle) else $error("capture in TOP mode");
   property p_flag_set;
      timer_tick && match_a |=> compare_flag_a;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set");
   property p_flag_clear;
      compare_flag_a_clear && !(timer_tick && match_a) |=> !compare_flag_a;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");
   property p_match;
      timer_tick |=> match_a == $past(equal_a);
   endproperty
   a_match: assert property (p_match) else $error("bad match");
   property p_buffer;
      $changed(compare_value_a) && $past(pwm) |-> $past(reload);
   endproperty
   a_buffer: assert property (p_buffer) else $error("early reload");
   property p_rdata;
      capture_low_read |=> cpu_rdata == $past(cap_low);
   endproperty
   a_rdata: assert property (p_rdata) else $error("bad low byte");
   property p_irq;
      compare_irq_a == (compare_flag_a && compare_irq_enable_a);
   endproperty
   a_irq: assert property (p_irq) else $error("bad request");
endmodule // capcmp_monitor
bind timer16_capture_compare capcmp_monitor u_monitor (.*);
`default_nettype wire

// File: bench/counter_unit_model.sv
// Purpose: Counter unit driving the block's counter inputs
// Assumes: Timer tick every second clock while running
// Notes: Counts up and wraps to zero at top_value
`timescale 1ns/1ps
`default_nettype none
module counter_unit_model
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Control
   input wire logic run,
   input wire logic [15:0] top_value,
   // Counter outputs
   output logic [15:0] counter_value,
   output logic timer_tick,
   output logic count_top,
   output logic count_bottom
);
   logic phase;
   always_ff @(posedge clock)
   begin
      if (!rst_n)
         {phase, counter_value} <= 17'h0_0000;
      else if (run)
         phase <= !phase;
      if (rst_n && timer_tick)
         counter_value <= count_top ? 16'h0000 : counter_value + 16'h0001;
   end
   // Stopping freezes the count, so captures see a known value
   assign timer_tick = run && phase;
   assign count_top = counter_value == top_value;
   assign count_bottom = counter_value == 16'h0000;
endmodule // counter_unit_model
`default_nettype wire

// File: bench/tb_timer16_capture_compare.sv
// Purpose: Self-checking bench for the capture/compare block
// Assumes: Counter unit model on the far side
// Notes: Inputs change 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_timer16_capture_compare;
   logic clock, rst_n, run, timer_tick, count_top, count_bottom, capture_filter_enable;
   logic capture_edge_rising, comparator_capture_select, compare_irq_enable_a;
   logic compare_irq_enable_b, capture_irq_enable, capture_input_pin, comparator_output;
   logic capture_high_read, capture_low_read, capture_flag_clear, capture_irq_ack;
   logic compare_flag_a_clear, compare_flag_b_clear, compare_irq_ack_a, compare_irq_ack_b;
   logic capture_flag, compare_flag_a, compare_flag_b, capture_irq, compare_irq_a;
   logic compare_irq_b, match_a, match_b, gen_top, gen_bottom;
   logic [3:0] waveform_mode_bits;
   logic [7:0] cpu_wdata, cpu_rdata;
   logic [15:0] counter_value, capture_value_reg, compare_value_a, compare_value_b, expect_value;
   logic [5:0] wr;
   wire logic capture_high_write, capture_low_write, compare_a_high_write;
   wire logic compare_a_low_write, compare_b_high_write, compare_b_low_write;
   int errors, num_checks, n;
   assign {compare_b_low_write, compare_b_high_write, compare_a_low_write,
      compare_a_high_write, capture_low_write, capture_high_write} = wr;
   counter_unit_model partner (.clock(clock), .rst_n(rst_n), .run(run), .top_value(16'h0040),
      .counter_value(counter_value), .timer_tick(timer_tick), .count_top(count_top),
      .count_bottom(count_bottom));
   timer16_capture_compare DUT (.*);
   initial
   begin
      clock = 1'b0;
      forever #5 clock = !clock;
   end
   task automatic give_verdict;
      if (errors == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic step(input int c);
      repeat (c) @(posedge clock);
      #1;
   endtask
   task automatic check(input logic [15:0] got, input logic [15:0] want);
      num_checks++;
      if (got !== want)
      begin
         errors++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, want);
      end
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   // High byte first: it only loads the shared latch
   task automatic write16(input int sel, input logic [15:0] v);
      wr = 6'h01 << (2 * sel);
      cpu_wdata = v[15:8];
      step(1);
      wr = 6'h02 << (2 * sel);
      cpu_wdata = v[7:0];
      step(1);
      // Idle cycle, so back-to-back calls never raise a strobe as it drops
      wr = 6'h00;
      step(1);
   endtask
   task automatic wait_for(ref logic s);
      n = 0;
      while (s !== 1'b1)
      begin
         step(1);
         n++;
         if (n > 300)
         begin
            errors++;
            $display("CHECK FAILED %0t wait timed out", $time);
            give_verdict();
         end
      end
   endtask
   initial
   begin
      {run, capture_filter_enable, comparator_capture_select, compare_irq_enable_a} = 4'h0;
      {compare_irq_enable_b, capture_irq_enable, capture_input_pin, comparator_output} = 4'h0;
      {capture_high_read, capture_low_read, capture_flag_clear, capture_irq_ack} = 4'h0;
      {compare_flag_a_clear, compare_flag_b_clear, compare_irq_ack_a, compare_irq_ack_b} = 4'h0;
      {rst_n, capture_edge_rising, waveform_mode_bits, cpu_wdata, wr} = 20'h0_0000;
      {errors, num_checks} = {32'h0000_0000, 32'h0000_0000};
      step(10);
      rst_n = 1'b1;
      capture_edge_rising = 1'b1;
      write16(1, 16'h0012);
      check(compare_value_a, 16'h0012);
      write16(2, 16'h0012);
      check(compare_value_b, 16'h0012);
      write16(0, 16'h1234);
      check(capture_value_reg, 16'h0000);
      compare_irq_enable_a = 1'b1;
      run = 1'b1;
      wait_for(match_a);
      check(counter_value, 16'h0013);
      check(16'(match_b), 16'h0001);
      wait_for(compare_flag_a);
      check(counter_value, 16'h0014);
      check(16'(compare_irq_a), 16'h0001);
      check(16'(compare_flag_b), 16'h0001);
      check(16'(compare_irq_b), 16'h0000);
      pulse(compare_flag_a_clear);
      check(16'(compare_flag_a), 16'h0000);
      pulse(compare_irq_ack_b);
      check(16'(compare_flag_b), 16'h0000);
      waveform_mode_bits = 4'hE;
      write16(1, 16'h0030);
      check(compare_value_a, 16'h0012);
      write16(0, 16'h5AAB);
      check(capture_value_reg, 16'h5AAB);
      capture_input_pin = 1'b1;
      step(8);
      check(16'(capture_flag), 16'h0000);
      capture_input_pin = 1'b0;
      wait_for(gen_top);
      step(2);
      check(compare_value_a, 16'h0030);
      check(16'(gen_bottom), 16'h0001);
      waveform_mode_bits = 4'h0;
      run = 1'b0;
      step(4);
      // Low read latches the high byte; a capture before the high read must not leak in
      pulse(capture_low_read);
      check({8'h00, cpu_rdata}, 16'h00AB);
      pulse(capture_flag_clear);
      expect_value = counter_value;
      capture_input_pin = 1'b1;
      wait_for(capture_flag);
      check(16'(n), 16'h0003);
      check(capture_value_reg, expect_value);
      pulse(capture_high_read);
      check({8'h00, cpu_rdata}, 16'h005A);
      run = 1'b1;
      step(7);
      run = 1'b0;
      capture_filter_enable = 1'b1;
      capture_edge_rising = 1'b0;
      step(6);
      pulse(capture_flag_clear);
      expect_value = counter_value;
      capture_input_pin = 1'b0;
      wait_for(capture_flag);
      check(16'(n), 16'h0007);
      check(capture_value_reg, expect_value);
      capture_edge_rising = 1'b1;
      step(2);
      pulse(capture_flag_clear);
      capture_input_pin = 1'b1;
      step(3);
      capture_input_pin = 1'b0;
      step(10);
      check(16'(capture_flag), 16'h0000);
      capture_filter_enable = 1'b0;
      comparator_capture_select = 1'b1;
      capture_irq_enable = 1'b1;
      step(4);
      pulse(capture_flag_clear);
      capture_input_pin = 1'b1;
      step(6);
      check(16'(capture_flag), 16'h0000);
      comparator_output = 1'b1;
      wait_for(capture_flag);
      check(16'(n), 16'h0003);
      check(16'(capture_irq), 16'h0001);
      pulse(capture_irq_ack);
      check(16'(capture_flag), 16'h0000);
      give_verdict();
   end
endmodule // tb_timer16_capture_compare
`default_nettype wire

// File: core/capture_filter.sv
// Purpose: Four-sample noise filter for the capture source
// Assumes: Input already synchronous to clock
// Notes: Output changes only when all samples agree
`timescale 1ns/1ps
`default_nettype none
module capture_filter
#(
   parameter int SAMPLES = capcmp_pkg::FILTER_SAMPLES
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Data
   input wire logic sample_in,
   output logic filtered
);
   import capcmp_pkg::*;

   typedef struct packed
   {
      logic [SAMPLES-1:0] history;
      logic out;
   } filter_state_type;

   filter_state_type state;
   filter_state_type next_state;

   always_comb
   begin
      next_state = state;
      next_state.history = {state.history[SAMPLES-2:0], sample_in};
      // Runs every system clock, so the prescaler never slows it
      if (&next_state.history)
      begin
         next_state.out = 1'b1;
      end
      else if (~|next_state.history)
      begin
         next_state.out = 1'b0;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign filtered = state.out;
endmodule // capture_filter
`default_nettype wire

// File: core/timer16_capture_compare.sv
// Purpose: Input capture and two-channel output compare of a 16-bit timer
// Assumes: Counter, TOP/BOTTOM and timer tick come from the counter unit
// Notes: CPU byte accesses arrive as one-cycle strobes with 8-bit data
// What this block does
// - Capture value register takes writes only in modes using it as TOP.
// - Capture source is the pin, or comparator output when select bit set.
// - Source switch may capture; software clears flag afterwards.
// - Enabled filter sits before edge detector adding four clocks latency.
// - Capture events blocked when capture defines TOP; filter and edge detector keep running.
// - Driving the capture pin's port output lets software cause a capture.
// - Filter output changes only after four agreeing samples.
// - Filter enabled by its bit, sampling on the system clock.
// - Each capture overwrites the capture value, read or not.
// - Capture flag clears when a one is written to it.
// - Compare flag requests interrupt when enabled; clears on ack or write one.
// - Match, TOP and BOTTOM signals pass on to the waveform generator.
// - Compare unit A value can serve as counter TOP.
// - Compare values double buffered in PWM modes, not normal or CLEAR_ON_MATCH_MODE.
// - Buffered value moves to active register only at TOP or BOTTOM.
// - CPU writes buffer when double buffering, else active register.
// - Capture flag sets in the same cycle the capture value loads.
// - Low byte read of capture latches high byte into shared latch.
// - High byte write loads latch; low byte write moves it up.
`timescale 1ns/1ps
`default_nettype none
module timer16_capture_compare
#(
   parameter int WIDTH = capcmp_pkg::COUNT_WIDTH
)
(
   // Clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // Counter unit
   input wire logic [capcmp_pkg::COUNT_WIDTH-1:0] counter_value,
   input wire logic timer_tick,
   input wire logic count_top,
   input wire logic count_bottom,
   // Control bits
   input wire logic [3:0] waveform_mode_bits,
   input wire logic capture_filter_enable,
   input wire logic capture_edge_rising,
   input wire logic comparator_capture_select,
   input wire logic compare_irq_enable_a,
   input wire logic compare_irq_enable_b,
   input wire logic capture_irq_enable,
   // Capture sources
   input wire logic capture_input_pin,
   input wire logic comparator_output,
   // CPU byte accesses
   input wire logic [7:0] cpu_wdata,
   input wire logic capture_high_write,
   input wire logic capture_low_write,
   input wire logic capture_high_read,
   input wire logic capture_low_read,
   input wire logic compare_a_high_write,
   input wire logic compare_a_low_write,
   input wire logic compare_b_high_write,
   input wire logic compare_b_low_write,
   output logic [7:0] cpu_rdata,
   // Flag clears and interrupt acknowledges
   input wire logic capture_flag_clear,
   input wire logic capture_irq_ack,
   input wire logic compare_flag_a_clear,
   input wire logic compare_flag_b_clear,
   input wire logic compare_irq_ack_a,
   input wire logic compare_irq_ack_b,
   // Status and requests
   output logic capture_flag,
   output logic compare_flag_a,
   output logic compare_flag_b,
   output logic capture_irq,
   output logic compare_irq_a,
   output logic compare_irq_b,
   // Waveform generator
   output logic match_a,
   output logic match_b,
   output logic gen_top,
   output logic gen_bottom,
   output logic [capcmp_pkg::COUNT_WIDTH-1:0] capture_value_reg,
   output logic [capcmp_pkg::COUNT_WIDTH-1:0] compare_value_a,
   output logic [capcmp_pkg::COUNT_WIDTH-1:0] compare_value_b
);
   import capcmp_pkg::*;

   typedef struct packed
   {
      logic [WIDTH-1:0] capture;
      logic [WIDTH-1:0] active_a;
      logic [WIDTH-1:0] active_b;
      logic [WIDTH-1:0] buffer_a;
      logic [WIDTH-1:0] buffer_b;
      logic [7:0] temp;
      logic [7:0] rdata;
      logic sync_raw;
      logic source_level;
      logic edge_prev;
      logic cap_flag;
      logic cmp_flag_a;
      logic cmp_flag_b;
      logic hit_a;
      logic hit_b;
   } unit_state_type;

   unit_state_type state;
   unit_state_type next_state;
   logic filtered;
   logic capture_top;
   logic pwm;
   logic source;
   logic detected;
   logic cap_event;

   assign capture_top = capture_is_top(waveform_mode_bits);
   assign pwm = mode_is_pwm(waveform_mode_bits);

   // Pin level includes whatever the port drives, so software can trigger
   assign source = comparator_capture_select ? comparator_output : capture_input_pin;

   // Filter taps the registered source, keeping the same base latency either way
   capture_filter #(
      .SAMPLES(FILTER_SAMPLES)
   ) filter_inst (
      .clock(clock),
      .rst_n(rst_n),
      .sample_in(state.source_level),
      .filtered(filtered)
   );

   // Filter placed ahead of the edge detector only when enabled
   assign detected = capture_filter_enable ? filtered : state.source_level;

   // Edge detector; a source switch that changes the level may also fire
   assign cap_event = !capture_top &&
      (capture_edge_rising ? (detected && !state.edge_prev)
                           : (!detected && state.edge_prev));

   function automatic logic [WIDTH-1:0] join_bytes(input logic [7:0] high, input logic [7:0] low);
      return {high, low};
   endfunction

   always_comb
   begin
      next_state = state;
      next_state.sync_raw = source;
      next_state.source_level = state.sync_raw;
      next_state.edge_prev = detected;

      // Shared high byte latch
      if (capture_high_write || compare_a_high_write || compare_b_high_write)
      begin
         next_state.temp = cpu_wdata;
      end
      else if (capture_low_read)
      begin
         next_state.temp = state.capture[15:8];
      end

      // Read data: high byte comes from the latch, never live
      if (capture_low_read)
      begin
         next_state.rdata = state.capture[7:0];
      end
      else if (capture_high_read)
      begin
         next_state.rdata = state.temp;
      end

      // Capture value: hardware capture or CPU write of TOP
      if (capture_low_write && capture_top)
      begin
         // Relies on software writing the high byte first
         next_state.capture = join_bytes(state.temp, cpu_wdata);
      end
      else if (cap_event)
      begin
         next_state.capture = counter_value;
      end

      // Capture flag: set wins over a clear in the same cycle
      if (capture_flag_clear || capture_irq_ack)
      begin
         next_state.cap_flag = 1'b0;
      end
      if (cap_event)
      begin
         next_state.cap_flag = 1'b1;
      end

      // Compare value writes go to buffer or active register
      if (compare_a_low_write)
      begin
         if (pwm)
         begin
            next_state.buffer_a = join_bytes(state.temp, cpu_wdata);
         end
         else
         begin
            next_state.active_a = join_bytes(state.temp, cpu_wdata);
            next_state.buffer_a = join_bytes(state.temp, cpu_wdata);
         end
      end
      if (compare_b_low_write)
      begin
         if (pwm)
         begin
            next_state.buffer_b = join_bytes(state.temp, cpu_wdata);
         end
         else
         begin
            next_state.active_b = join_bytes(state.temp, cpu_wdata);
            next_state.buffer_b = join_bytes(state.temp, cpu_wdata);
         end
      end

      // Buffered update only at the ends of the count, to avoid odd pulses
      if (pwm && timer_tick && (count_top || count_bottom))
      begin
         next_state.active_a = state.buffer_a;
         next_state.active_b = state.buffer_b;
      end

      // Match registered on the timer tick, flag set on the next tick
      if (timer_tick)
      begin
         next_state.hit_a = (counter_value == state.active_a);
         next_state.hit_b = (counter_value == state.active_b);
      end
      if (compare_flag_a_clear || compare_irq_ack_a)
      begin
         next_state.cmp_flag_a = 1'b0;
      end
      if (compare_flag_b_clear || compare_irq_ack_b)
      begin
         next_state.cmp_flag_b = 1'b0;
      end
      if (timer_tick && state.hit_a)
      begin
         next_state.cmp_flag_a = 1'b1;
      end
      if (timer_tick && state.hit_b)
      begin
         next_state.cmp_flag_b = 1'b1;
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
      begin
         state <= '0;
      end
      else
      begin
         state <= next_state;
      end
   end

   assign cpu_rdata = state.rdata;
   assign capture_flag = state.cap_flag;
   assign compare_flag_a = state.cmp_flag_a;
   assign compare_flag_b = state.cmp_flag_b;
   assign capture_irq = state.cap_flag && capture_irq_enable;
   assign compare_irq_a = state.cmp_flag_a && compare_irq_enable_a;
   assign compare_irq_b = state.cmp_flag_b && compare_irq_enable_b;
   assign match_a = state.hit_a;
   assign match_b = state.hit_b;
   assign gen_top = count_top;
   assign gen_bottom = count_bottom;
   assign capture_value_reg = state.capture;
   // Counter unit uses this as TOP in the modes that select it
   assign compare_value_a = state.active_a;
   assign compare_value_b = state.active_b;
endmodule // timer16_capture_compare
`default_nettype wire

// File: inc/capcmp_pkg.sv
// Purpose: Shared constants for the timer capture/compare block
// Assumes: 16-bit counter supplied from outside, 8-bit CPU data bus
// Notes: Mode codes follow the 4-bit waveform mode field
package capcmp_pkg;
   localparam int COUNT_WIDTH = 16;
   localparam int FILTER_SAMPLES = 4;
   // Waveform mode codes of interest
   localparam logic [3:0] MODE_NORMAL = 4'h0;
   localparam logic [3:0] MODE_CTC_COMPARE = 4'h4;
   localparam logic [3:0] MODE_CTC_CAPTURE = 4'hC;
   localparam logic [3:0] MODE_PWM_PFC_CAPTURE = 4'h8;
   localparam logic [3:0] MODE_PWM_PC_CAPTURE = 4'hA;
   localparam logic [3:0] MODE_PWM_FAST_CAPTURE = 4'hE;
   localparam logic [3:0] MODE_RESERVED = 4'hD;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic [7:0] BYTE_RESET = 8'h00;

   // Capture register used as TOP
   function automatic logic capture_is_top(input logic [3:0] mode);
      return (mode == MODE_PWM_PFC_CAPTURE) || (mode == MODE_PWM_PC_CAPTURE) ||
             (mode == MODE_CTC_CAPTURE) || (mode == MODE_PWM_FAST_CAPTURE);
   endfunction

   // PWM modes: all except normal, both clear-on-match modes and reserved
   function automatic logic mode_is_pwm(input logic [3:0] mode);
      return !((mode == MODE_NORMAL) || (mode == MODE_CTC_COMPARE) ||
               (mode == MODE_CTC_CAPTURE) || (mode == MODE_RESERVED));
   endfunction
endpackage
